// ---- pkg/shs_pkg.sv ----
// Constants and carrier types for the sensor hub slot and status registers
`default_nettype none

package shs_pkg;

  // Register word indexes; byte address is four times the index
  localparam logic [5:0] IDX_HUB_CTRL    = 6'h14;
  localparam logic [5:0] IDX_EXT1_BUSADR = 6'h15;
  localparam logic [5:0] IDX_EXT1_PTR    = 6'h16;
  localparam logic [5:0] IDX_EXT4_BUSADR = 6'h1E;
  localparam logic [5:0] IDX_EXT4_PTR    = 6'h1F;
  localparam logic [5:0] IDX_EXT4_CFG    = 6'h20;
  localparam logic [5:0] IDX_EXT1_WBYTE  = 6'h21;
  localparam logic [5:0] IDX_HUB_STATUS  = 6'h22;
  localparam logic [5:0] IDX_IRQ_STATUS  = 6'h30;
  localparam logic [5:0] IDX_IRQ_MASK    = 6'h31;

  // Reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;

  // Hub control fields
  localparam int CTRL_HUB_EN_BIT    = 0;
  localparam int CTRL_SINGLE_WR_BIT = 6;

  // Bus address register fields: [7:1] address, [0] direction or read enable
  localparam int BUSADR_DIR_BIT = 0;

  // Fourth slot configuration fields
  localparam int CFG_BATCH_BIT  = 3;
  localparam int CFG_COUNT_LSB  = 0;
  localparam int CFG_COUNT_MSB  = 2;
  localparam int CFG_RSVD_LSB   = 4;
  localparam int CFG_RSVD_MSB   = 7;

  // Hub status fields
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_NACK_LSB  = 3;
  localparam int STAT_WDONE_BIT = 7;

  // Interrupt status and mask layout
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_NACK_LSB  = 1;
  localparam int IRQ_WDONE_BIT = 5;
  localparam int IRQ_WIDTH     = 6;

  // Bits per byte before the acknowledge bit
  localparam logic [3:0] ACK_BIT_POS = 4'h8;

  // Line phases of the bus engine
  typedef enum logic [1:0] {PH_IDLE, PH_START, PH_BITS, PH_STOP} shs_phase_e;

  // Byte steps inside one slot transaction
  typedef enum logic [2:0] {ST_ADDR_W, ST_REG, ST_WDATA, ST_ADDR_R, ST_RDATA} shs_step_e;

  // Byte read from an external sensor
  typedef struct packed {
    logic       valid;
    logic [1:0] slot;
    logic [7:0] data;
    logic       fifoPush;
  } shs_rd_s;

  // Synchronised view of the sensor bus lines
  typedef struct packed {
    logic sclRise;
    logic sclFall;
    logic sdaLevel;
  } shs_line_s;

endpackage : shs_pkg

`default_nettype wire

// ---- design/shs_link_sync.sv ----
// Synchroniser for the sensor bus clock and data lines, edge finder for the clock line only
`default_nettype none

module shs_link_sync (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         linkClk,
  input  wire logic         sdaIn,
  output shs_pkg::shs_line_s line
);

  typedef struct packed {
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic       sclLast;
  } shs_sync_s;

  shs_sync_s s;
  shs_sync_s next_s;

  // Two stages per line, third stage of the clock for edge finding
  always_comb begin
    next_s         = s;
    next_s.sclSync = {s.sclSync[0], linkClk};
    next_s.sdaSync = {s.sdaSync[0], sdaIn};
    next_s.sclLast = s.sclSync[1];
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '1;  // Idle level of both lines, so no false edge follows reset
    end else begin
      s <= next_s;
    end
  end

  // Edges come from the second and third stages only
  assign line.sclRise  = s.sclSync[1] & ~s.sclLast;
  assign line.sclFall  = ~s.sclSync[1] & s.sclLast;
  assign line.sdaLevel = s.sdaSync[1];

endmodule : shs_link_sync

`default_nettype wire

// ---- design/shs_hub_regs.sv ----
// Sensor hub slot registers, status register and bus sequencer
//
// Our own choice: the Avalon-MM register port.
`default_nettype none

module shs_hub_regs (
  input  wire logic            core_clk,
  input  wire logic            rst_b,
  input  wire logic [7:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  input  wire logic [3:0]      avs_byteenable,
  output logic      [31:0]     avs_readdata,
  output logic                 avs_waitrequest,
  input  wire logic            hubTick,
  input  wire logic [1:0]      otherSlotNack,
  input  wire logic            linkClk,
  input  wire logic            sdaIn,
  output logic                 sdaOut,
  output logic                 sdaOe,
  output shs_pkg::shs_rd_s     hubData,
  output logic                 hubCycleDone,
  output logic                 irq
);

  typedef struct packed {
    logic                           busAck;
    logic [7:0]                     rdData;
    logic [7:0]                     hubCtrl;
    logic [7:0]                     ext1BusAdr;
    logic [7:0]                     ext1Ptr;
    logic [7:0]                     ext4BusAdr;
    logic [7:0]                     ext4Ptr;
    logic [7:0]                     ext4Cfg;
    logic [7:0]                     ext1WByte;
    logic [3:0]                     nackFlags;
    logic                           wrDone;
    logic                           hubDone;
    logic [shs_pkg::IRQ_WIDTH-1:0]  irqStat;
    logic [shs_pkg::IRQ_WIDTH-1:0]  irqMask;
    shs_pkg::shs_phase_e            phase;
    shs_pkg::shs_step_e             step;
    logic                           onExt4;
    logic [7:0]                     shReg;
    logic [3:0]                     bitCnt;
    logic [2:0]                     remain;
    logic                           sdaDrive;
    shs_pkg::shs_rd_s               out;
  } shs_state_s;

  shs_state_s                    s;
  shs_state_s                    next_s;
  shs_pkg::shs_line_s            line;
  logic [5:0]                    regIdx;
  logic                          access;
  logic                          ext1Run;
  logic                          ext4Run;
  logic [2:0]                    ext4Count;
  logic [shs_pkg::IRQ_WIDTH-1:0] evt;

  // Address byte on the sensor bus: 7-bit address then read flag
  function automatic logic [7:0] addrByte(input logic [7:0] busAdr, input logic rd);
    addrByte = {busAdr[7:1], rd};
  endfunction : addrByte

  // Line synchroniser for the sensor bus
  shs_link_sync u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .linkClk  (linkClk),
    .sdaIn    (sdaIn),
    .line     (line)
  );

  // Bus decode and slot eligibility
  assign regIdx    = avs_address[7:2];
  assign access    = (avs_read | avs_write) & ~s.busAck;
  assign ext4Count = s.ext4Cfg[shs_pkg::CFG_COUNT_MSB:shs_pkg::CFG_COUNT_LSB];
  // Slot one write is skipped once a single write has completed
  assign ext1Run   = s.ext1BusAdr[shs_pkg::BUSADR_DIR_BIT] | ~s.hubCtrl[shs_pkg::CTRL_SINGLE_WR_BIT]
                     | ~s.wrDone;
  assign ext4Run   = s.ext4BusAdr[shs_pkg::BUSADR_DIR_BIT] & (ext4Count != 3'h0);

  // Next state of registers and sequencer
  always_comb begin
    next_s             = s;
    evt                = '0;
    next_s.out.valid   = 1'b0;
    next_s.out.fifoPush = 1'b0;
    next_s.busAck      = access;

    // Register read, data latched on the first edge of the access
    if (access && avs_read) begin
      unique case (regIdx)
        shs_pkg::IDX_HUB_CTRL:    next_s.rdData = s.hubCtrl;
        shs_pkg::IDX_EXT1_BUSADR: next_s.rdData = s.ext1BusAdr;
        shs_pkg::IDX_EXT1_PTR:    next_s.rdData = s.ext1Ptr;
        shs_pkg::IDX_EXT4_BUSADR: next_s.rdData = s.ext4BusAdr;
        shs_pkg::IDX_EXT4_PTR:    next_s.rdData = s.ext4Ptr;
        shs_pkg::IDX_EXT4_CFG:    next_s.rdData = s.ext4Cfg;
        shs_pkg::IDX_EXT1_WBYTE:  next_s.rdData = s.ext1WByte;
        shs_pkg::IDX_HUB_STATUS:  next_s.rdData = {s.wrDone, s.nackFlags, 2'b00, s.hubDone};
        shs_pkg::IDX_IRQ_STATUS:  next_s.rdData = {2'b00, s.irqStat};
        shs_pkg::IDX_IRQ_MASK:    next_s.rdData = {2'b00, s.irqMask};
        default:                  next_s.rdData = 8'h00;
      endcase
    end

    // Register write on byte lane 0; status is read-only
    if (access && avs_write && avs_byteenable[0]) begin
      unique case (regIdx)
        shs_pkg::IDX_HUB_CTRL: begin
          next_s.hubCtrl = avs_writedata[7:0];
          next_s.wrDone  = 1'b0;  // Re-arms the single write
        end
        shs_pkg::IDX_EXT1_BUSADR: next_s.ext1BusAdr = avs_writedata[7:0];
        shs_pkg::IDX_EXT1_PTR:    next_s.ext1Ptr    = avs_writedata[7:0];
        shs_pkg::IDX_EXT4_BUSADR: next_s.ext4BusAdr = avs_writedata[7:0];
        shs_pkg::IDX_EXT4_PTR:    next_s.ext4Ptr    = avs_writedata[7:0];
        shs_pkg::IDX_EXT4_CFG:    next_s.ext4Cfg    = avs_writedata[7:0];
        shs_pkg::IDX_EXT1_WBYTE:  next_s.ext1WByte  = avs_writedata[7:0];
        shs_pkg::IDX_IRQ_MASK:    next_s.irqMask    = avs_writedata[shs_pkg::IRQ_WIDTH-1:0];
        default: ;
      endcase
    end

    // Interrupt status clears on the accepting edge of its read
    if (s.busAck && avs_read && regIdx == shs_pkg::IDX_IRQ_STATUS) begin
      next_s.irqStat = '0;
    end

    // New hub cycle: clear done and flags, pick the first slot
    if (hubTick && s.hubCtrl[shs_pkg::CTRL_HUB_EN_BIT] && s.phase == shs_pkg::PH_IDLE) begin
      next_s.hubDone   = 1'b0;
      next_s.nackFlags = 4'h0;
      next_s.step      = shs_pkg::ST_ADDR_W;
      next_s.bitCnt    = 4'h0;
      if (ext1Run) begin
        next_s.onExt4 = 1'b0;
        next_s.shReg  = addrByte(s.ext1BusAdr, 1'b0);
        next_s.phase  = shs_pkg::PH_START;
      end else if (ext4Run) begin
        next_s.onExt4 = 1'b1;
        next_s.shReg  = addrByte(s.ext4BusAdr, 1'b0);
        next_s.phase  = shs_pkg::PH_START;
      end else begin
        next_s.hubDone            = 1'b1;
        evt[shs_pkg::IRQ_DONE_BIT] = 1'b1;
      end
    end

    // Bus engine
    unique case (s.phase)
      shs_pkg::PH_IDLE: ;

      // Release data while clock is low, pull it low while clock is high
      shs_pkg::PH_START: begin
        if (line.sclFall) begin
          next_s.sdaDrive = 1'b0;
        end else if (line.sclRise) begin
          next_s.sdaDrive = 1'b1;
          next_s.bitCnt   = 4'h0;
          next_s.phase    = shs_pkg::PH_BITS;
        end
      end

      // Data changes on clock fall and is sampled on clock rise
      shs_pkg::PH_BITS: begin
        if (line.sclFall) begin
          if (s.bitCnt != shs_pkg::ACK_BIT_POS) begin
            next_s.sdaDrive = (s.step != shs_pkg::ST_RDATA) & ~s.shReg[7];
          end else begin
            // Acknowledge every read byte but the last
            next_s.sdaDrive = (s.step == shs_pkg::ST_RDATA) & (s.remain != 3'h1);
          end
        end else if (line.sclRise) begin
          if (s.bitCnt != shs_pkg::ACK_BIT_POS) begin
            next_s.shReg  = {s.shReg[6:0], line.sdaLevel};
            next_s.bitCnt = s.bitCnt + 4'h1;
          end else begin
            next_s.bitCnt = 4'h0;
            if (s.step == shs_pkg::ST_RDATA) begin
              next_s.out.valid    = 1'b1;
              next_s.out.slot     = s.onExt4 ? 2'h3 : 2'h0;
              next_s.out.data     = s.shReg;
              next_s.out.fifoPush = s.onExt4 & s.ext4Cfg[shs_pkg::CFG_BATCH_BIT];
              next_s.remain       = s.remain - 3'h1;
              if (s.remain == 3'h1) begin
                next_s.phase = shs_pkg::PH_STOP;
              end
            end else if (line.sdaLevel) begin
              // Not acknowledged: flag the slot and end its transfer
              if (s.onExt4) begin
                next_s.nackFlags[3]             = 1'b1;
                evt[shs_pkg::IRQ_NACK_LSB + 3]  = 1'b1;
              end else begin
                next_s.nackFlags[0]             = 1'b1;
                evt[shs_pkg::IRQ_NACK_LSB]      = 1'b1;
              end
              next_s.phase = shs_pkg::PH_STOP;
            end else begin
              unique case (s.step)
                shs_pkg::ST_ADDR_W: begin
                  next_s.step  = shs_pkg::ST_REG;
                  next_s.shReg = s.onExt4 ? s.ext4Ptr : s.ext1Ptr;
                end
                shs_pkg::ST_REG: begin
                  if (!s.onExt4 && !s.ext1BusAdr[shs_pkg::BUSADR_DIR_BIT]) begin
                    next_s.step  = shs_pkg::ST_WDATA;
                    next_s.shReg = s.ext1WByte;
                  end else begin
                    next_s.step  = shs_pkg::ST_ADDR_R;
                    next_s.shReg = addrByte(s.onExt4 ? s.ext4BusAdr : s.ext1BusAdr, 1'b1);
                    next_s.phase = shs_pkg::PH_START;
                  end
                end
                shs_pkg::ST_WDATA: begin
                  if (s.hubCtrl[shs_pkg::CTRL_SINGLE_WR_BIT]) begin
                    next_s.wrDone               = 1'b1;
                    evt[shs_pkg::IRQ_WDONE_BIT] = 1'b1;
                  end
                  next_s.phase = shs_pkg::PH_STOP;
                end
                shs_pkg::ST_ADDR_R: begin
                  next_s.step   = shs_pkg::ST_RDATA;
                  next_s.remain = s.onExt4 ? ext4Count : 3'h1;
                end
                shs_pkg::ST_RDATA: ;
              endcase
            end
          end
        end
      end

      // Pull data low on a clock fall, release it while clock is high
      shs_pkg::PH_STOP: begin
        if (line.sclFall) begin
          next_s.sdaDrive = 1'b1;
        end else if (line.sclRise && s.sdaDrive) begin
          next_s.sdaDrive = 1'b0;
          next_s.step     = shs_pkg::ST_ADDR_W;
          next_s.bitCnt   = 4'h0;
          if (!s.onExt4 && ext4Run) begin
            next_s.onExt4 = 1'b1;
            next_s.shReg  = addrByte(s.ext4BusAdr, 1'b0);
            next_s.phase  = shs_pkg::PH_START;
          end else begin
            next_s.phase              = shs_pkg::PH_IDLE;
            next_s.hubDone            = 1'b1;
            evt[shs_pkg::IRQ_DONE_BIT] = 1'b1;
          end
        end
      end
    endcase

    // Flags from the slots that run elsewhere in the hub
    if (otherSlotNack[0]) begin
      next_s.nackFlags[1]            = 1'b1;
      evt[shs_pkg::IRQ_NACK_LSB + 1] = 1'b1;
    end
    if (otherSlotNack[1]) begin
      next_s.nackFlags[2]            = 1'b1;
      evt[shs_pkg::IRQ_NACK_LSB + 2] = 1'b1;
    end

    // Events are applied after the clear so a same-cycle set survives
    next_s.irqStat = next_s.irqStat | evt;
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s            <= '0;
      s.hubCtrl    <= shs_pkg::REG_RESET;
      s.ext4Cfg    <= shs_pkg::REG_RESET;
      s.ext1WByte  <= shs_pkg::REG_RESET;
      s.phase      <= shs_pkg::PH_IDLE;
      s.step       <= shs_pkg::ST_ADDR_W;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign avs_waitrequest = (avs_read | avs_write) & ~s.busAck;
  assign avs_readdata    = {24'h00_0000, s.rdData};
  assign sdaOut          = 1'b0;       // Open drain: only ever pulls low
  assign sdaOe           = s.sdaDrive;
  assign hubData         = s.out;
  assign hubCycleDone    = s.hubDone;
  assign irq             = |(s.irqStat & s.irqMask);

endmodule : shs_hub_regs

`default_nettype wire

// ---- dv/shs_hub_regs_sva.sv ----
// Concurrent checks on the sensor hub register block ports
`default_nettype none

module shs_hub_regs_sva (
  input wire logic             core_clk,
  input wire logic             rst_b,
  input wire logic [7:0]       avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_readdata,
  input wire logic             avs_waitrequest,
  input wire logic             hubTick,
  input wire logic [1:0]       otherSlotNack,
  input wire logic             sdaOe,
  input wire shs_pkg::shs_rd_s hubData,
  input wire logic             hubCycleDone
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Accepted read of the hub status word
  sequence s_stat_rd;
    avs_read && !avs_waitrequest && avs_address[7:2] == shs_pkg::IDX_HUB_STATUS;
  endsequence

  // Second slot no-ack pulse, then a status read before any new hub cycle
  sequence s_ext2_nack;
    otherSlotNack[0] ##2 (!hubTick throughout (##[0:20] s_stat_rd));
  endsequence

  // Bus answers and status contents
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request kept waiting past one cycle");
  a_status_zero: assert property (s_stat_rd |-> avs_readdata[2:1] == 2'b00 && avs_readdata[31:8] == 24'h00_0000)
    else $error("status spare bits not zero");
  a_done_read: assert property (s_stat_rd ##0 $stable(hubCycleDone) |-> avs_readdata[0] == hubCycleDone)
    else $error("status done bit differs from done output");
  a_nack_flag: assert property (s_ext2_nack |-> avs_readdata[shs_pkg::STAT_NACK_LSB + 1])
    else $error("second slot no-ack flag not set");

  // Hub cycle framing
  a_done_start: assert property ($fell(hubCycleDone) |-> $past(hubTick))
    else $error("done flag cleared without a cycle start");
  a_done_holds: assert property (hubCycleDone && !hubTick |=> hubCycleDone)
    else $error("done flag dropped while idle");
  a_line_idle: assert property (hubCycleDone && $past(hubCycleDone) |-> !sdaOe)
    else $error("data line driven after cycle concluded");

  // Read bytes
  a_read_busy: assert property (hubData.valid |-> !hubCycleDone)
    else $error("read byte outside a hub cycle");
  a_valid_pulse: assert property (hubData.valid |=> (!hubData.valid) [*8])
    else $error("read bytes closer than a byte time");
  a_push_slot4: assert property (hubData.fifoPush |-> hubData.valid && hubData.slot == 2'd3)
    else $error("batch push not from fourth slot");
endmodule : shs_hub_regs_sva

bind shs_hub_regs shs_hub_regs_sva u_sva (
  .core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .hubTick, .otherSlotNack, .sdaOe, .hubData, .hubCycleDone
);

`default_nettype wire

// ---- dv/shs_sensor_model.sv ----
// Behavioural external sensor on the open-drain sensor bus
`default_nettype none

module shs_sensor_model (
  output logic            scl,
  input  wire logic       sda,
  output logic            pull,
  input  wire logic       run,
  input  wire logic       nack,
  input  wire logic [7:0] txBase
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] shIn;
  logic [7:0] tx;
  logic       rd;
  logic       rdNext;
  logic       framed;
  int         bitCnt;
  int         nByte;
  logic [7:0] got[$];

  // Idle values
  initial begin
    scl = 1'b1;
    pull = 1'b0;
    rd = 1'b0;
    rdNext = 1'b0;
    framed = 1'b0;
    bitCnt = 0;
    nByte = 0;
  end

  // Clock runs only while a frame is wanted, parks high otherwise
  always begin
    if (run) begin
      #160 scl = 1'b0;
      #160 scl = 1'b1;
    end else @(posedge run);
  end

  // Start or repeated start restarts byte framing; stop ends the frame
  always @(negedge sda) if (scl) begin
    bitCnt = 0;
    nByte = 0;
    rd = 1'b0;
    rdNext = 1'b0;
    framed = 1'b1;
  end
  always @(posedge sda) if (scl) framed = 1'b0;

  // Bits sampled on the rise; a high master acknowledge ends a read burst
  always @(posedge scl) begin
    if (rd && bitCnt == 8 && sda) rd = 1'b0;
    shIn = {shIn[6:0], sda};
    bitCnt++;
  end

  // Line changed after the fall: acknowledge, release or read data
  always @(negedge scl) if (framed) begin
    if (bitCnt == 8) begin
      if (!rd) got.push_back(shIn);
      if (nByte == 0) rdNext = shIn[0];
      pull = !rd && !nack;
      nByte++;
    end else if (bitCnt == 9) begin
      bitCnt = 0;
      tx = rd ? tx + 8'h01 : txBase;
      if (rdNext && !rd && nByte == 1) rd = 1'b1;
      pull = rd && !tx[7];
    end else if (rd) pull = !tx[7 - bitCnt];
  end
endmodule : shs_sensor_model

`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the sensor hub slot and status registers
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic             core_clk;
  logic             rst_b;
  logic [7:0]       avs_address;
  logic             avs_read;
  logic             avs_write;
  logic [31:0]      avs_writedata;
  logic [3:0]       avs_byteenable;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic             hubTick;
  logic [1:0]       otherSlotNack;
  wire logic        linkClk;
  wire logic        sda;
  wire logic        pull;
  logic             sdaOut;
  logic             sdaOe;
  logic             hubCycleDone;
  logic             irq;
  logic             run;
  logic             nk;
  logic [7:0]       base;
  logic [15:0]      lfsr;
  logic [31:0]      rdata;
  int               n_errors;
  int               compares;
  int               cyc;
  shs_pkg::shs_rd_s hubData;
  shs_pkg::shs_rd_s rdq[$];
  shs_pkg::shs_rd_s eh[$];
  logic [7:0]       eq[$];

  // Open-drain data line with pull-up
  assign sda = (sdaOe ? sdaOut : 1'b1) & !pull;

  shs_hub_regs u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hubTick(hubTick),
    .otherSlotNack(otherSlotNack), .linkClk(linkClk), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .hubData(hubData), .hubCycleDone(hubCycleDone), .irq(irq)
  );

  shs_sensor_model u_sens (
    .scl(linkClk), .sda(sda), .pull(pull), .run(run), .nack(nk), .txBase(base)
  );

  // Clock, read byte monitor and hang limit
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (hubData.valid === 1'b1) rdq.push_back(hubData);
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One Avalon transfer held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, d};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rdata, {24'h00_0000, exp});
  endtask : rdc

  // One hub cycle with the sensor clock running
  task automatic cycle();
    int n;
    u_sens.got.delete();
    rdq.delete();
    @(posedge core_clk);
    run <= 1'b1;
    hubTick <= 1'b1;
    @(posedge core_clk);
    hubTick <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hubCycleDone !== 1'b1);
    repeat (8) @(posedge core_clk);
    run <= 1'b0;
  endtask : cycle

  task automatic stop_test();
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    logic [5:0] rl[6];
    logic [7:0] a1, a4, p1, p4, wb, cfg, mask, expStat, expIrq;
    logic       dir1, en4, single, batch, wdone, run1, run4, newW;
    logic [2:0] cnt;
    rl = '{shs_pkg::IDX_EXT4_PTR, shs_pkg::IDX_EXT4_CFG, shs_pkg::IDX_EXT1_WBYTE,
           shs_pkg::IDX_HUB_STATUS, shs_pkg::IDX_IRQ_STATUS, 6'h3F};
    {rst_b, avs_read, avs_write, hubTick, run, nk} = '0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h1;
    otherSlotNack = 2'b00;
    base = 8'h00;
    lfsr = 16'hEB6C;
    wdone = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (rl[i]) rdc(rl[i], 8'h00);
    bus(1'b1, shs_pkg::IDX_HUB_STATUS, 8'hFF);
    rdc(shs_pkg::IDX_HUB_STATUS, 8'h00);
    avs_byteenable <= 4'h0;
    bus(1'b1, shs_pkg::IDX_EXT1_WBYTE, 8'hFF);
    avs_byteenable <= 4'h1;
    rdc(shs_pkg::IDX_EXT1_WBYTE, 8'h00);
    for (int s = 0; s < 5; s++) begin
      if (s != 3) begin
        dir1 = (s == 1);
        en4 = (s != 1);
        single = (s == 2);
        nk = (s == 4);
        batch = (s == 0);
        cnt = (s == 2) ? 3'd0 : 3'(1 + rnd() % 3);
        {a1, a4, p1, p4, wb, base} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        cfg = {4'h0, batch, cnt};
        mask = (s == 1) ? 8'h00 : 8'h3F;
        wdone = 1'b0;
        bus(1'b1, shs_pkg::IDX_HUB_CTRL, {1'b0, single, 5'h00, 1'b1});
        bus(1'b1, shs_pkg::IDX_EXT1_BUSADR, {a1[7:1], dir1});
        bus(1'b1, shs_pkg::IDX_EXT1_PTR, p1);
        bus(1'b1, shs_pkg::IDX_EXT4_BUSADR, {a4[7:1], en4});
        bus(1'b1, shs_pkg::IDX_EXT4_PTR, p4);
        bus(1'b1, shs_pkg::IDX_EXT4_CFG, cfg);
        bus(1'b1, shs_pkg::IDX_EXT1_WBYTE, wb);
        bus(1'b1, shs_pkg::IDX_IRQ_MASK, mask);
        rdc(shs_pkg::IDX_EXT4_PTR, p4);
        rdc(shs_pkg::IDX_EXT4_CFG, cfg);
        rdc(shs_pkg::IDX_EXT1_WBYTE, wb);
      end
      run1 = !(single && wdone && !dir1);
      run4 = en4 && cnt != 3'd0;
      newW = single && run1 && !dir1 && !nk;
      eq.delete();
      eh.delete();
      if (run1) eq.push_back({a1[7:1], 1'b0});
      if (run1 && !nk) eq.push_back(p1);
      if (run1 && !nk) eq.push_back(dir1 ? {a1[7:1], 1'b1} : wb);
      if (run1 && dir1 && !nk) eh.push_back('{1'b1, 2'd0, base, 1'b0});
      if (run4) eq.push_back({a4[7:1], 1'b0});
      if (run4 && !nk) eq.push_back(p4);
      if (run4 && !nk) eq.push_back({a4[7:1], 1'b1});
      for (int i = 0; i < cnt; i++) if (run4 && !nk) eh.push_back('{1'b1, 2'd3, 8'(base + i), batch});
      expStat = {wdone | newW, nk && run4, 2'b00, nk && run1, 2'b00, 1'b1};
      expIrq = {2'b00, newW, nk && run4, 2'b00, nk && run1, 1'b1};
      wdone = wdone | newW;
      cycle();
      chk(32'(u_sens.got.size()), 32'(eq.size()));
      foreach (eq[i]) chk(u_sens.got[i], eq[i]);
      chk(32'(rdq.size()), 32'(eh.size()));
      foreach (eh[i]) chk(rdq[i], eh[i]);
      chk(irq, |(expIrq & mask));
      rdc(shs_pkg::IDX_HUB_STATUS, expStat);
      rdc(shs_pkg::IDX_IRQ_STATUS, expIrq);
      @(posedge core_clk);
      chk(irq, 1'b0);
    end
    @(posedge core_clk);
    otherSlotNack <= 2'b11;
    @(posedge core_clk);
    otherSlotNack <= 2'b00;
    rdc(shs_pkg::IDX_HUB_STATUS, expStat | 8'h30);
    rdc(shs_pkg::IDX_IRQ_STATUS, 8'h0C);
    rdc(6'h3F, 8'h00);
    stop_test();
  end
endmodule : tb

`default_nettype wire
